// [inc/mailbox_defs.svh]
`ifndef MAILBOX_DEFS_SVH
`define MAILBOX_DEFS_SVH
`define MBX_CHANS      2
`define MBX_DW         8
`define MBX_AW         16
`define MBX_ADDR_DATA0 16'h00D0
`define MBX_ADDR_DATA1 16'h00D1
`define MBX_ADDR_CTRL  16'h00D2
`define MBX_ADDR_ASSIGN 16'h00E6
`define MBX_REQ_BIT    4
`define MBX_WE_BIT     6
`define MBX_VALID_BIT  6
`define MBX_EN_BIT     3
`define MBX_EN_STRIDE  4
`define MBX_PIN_IDLE   7'h3F
`define MBX_BUF_DEPTH  2
`endif

// [inc/mailbox_pkg.sv]
// Purpose: shared types of the host DMA mailbox
// Assumes: constants come from mailbox_defs.svh
// Notes:   one state struct carries all flops of the top module
`include "mailbox_defs.svh"
package mailbox_pkg;
    typedef enum logic [1:0] {MODE_POLL, MODE_HOST_WRITE, MODE_HOST_READ} chan_mode_t;
    typedef logic [`MBX_DW-1:0] byte_t;
    typedef struct packed {
        logic [`MBX_CHANS-1:0]          flag;
        logic [`MBX_CHANS-1:0]          valid;
        byte_t [`MBX_CHANS-1:0]         to_host;
        byte_t [`MBX_CHANS-1:0]         from_host;
        byte_t [`MBX_CHANS-1:0]         capture;
        byte_t                          assign_reg;
        chan_mode_t [`MBX_CHANS-1:0]    mode;
        logic [`MBX_CHANS-1:0]          rcyc;
        logic [`MBX_CHANS-1:0]          wcyc;
        byte_t                          hdata;
        byte_t                          rdata;
    } mbx_state_t;
endpackage

// [logic/pin_sync.sv]
// Purpose: three-stage synchroniser for asynchronous host pins
// Assumes: a change counts once stages two and three agree
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // pins in, clean levels out
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_t;
    sync_t st_q, st_d;

    // agreement filter keeps a single metastable sample from counting
    always_comb
    begin
        st_d.s1  = raw;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.out = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.out);
        if (reset)
        begin
            st_d = {IDLE, IDLE, IDLE, IDLE};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    assign clean = st_q.out;
endmodule

// [logic/byte_buffer.sv]
// Purpose: small FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full drops in_ready, which stalls the filling logic
`timescale 1ns/1ps
module byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } buf_t;
    buf_t st_q, st_d;
    logic push, pop;

    assign in_ready  = st_q.cnt < (PW+1)'(DEPTH);
    assign out_valid = st_q.cnt != '0;
    assign out_data  = st_q.mem[st_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wp] = in_data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop)
        begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (reset)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end
endmodule

// [logic/host_dma_mailbox.sv]
// Purpose: two-channel byte mailbox between a host DMA controller and local CPU/DMA
// Assumes: host pins are asynchronous; local bus and local DMA are on sys_clk
// Notes:   isa_mode selects ISA pins, else card pins with channel 0 only
`timescale 1ns/1ps
`include "mailbox_defs.svh"
module host_dma_mailbox #(
    parameter mailbox_pkg::byte_t ID_CODE0 = 8'hA5, // arbitrary identity value
    parameter mailbox_pkg::byte_t ID_CODE1 = 8'hA5  // arbitrary identity value
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // configuration from the bus-mode modules
    input  wire logic                      isa_mode,
    input  wire logic [`MBX_CHANS-1:0]     chan_enable,
    // local cpu i/o port
    input  wire logic [`MBX_AW-1:0]        loc_addr,
    input  wire logic                      loc_wr,
    input  wire logic                      loc_rd,
    input  wire mailbox_pkg::byte_t        loc_wdata,
    output mailbox_pkg::byte_t             loc_rdata,
    // local dma channels
    output logic [`MBX_CHANS-1:0]          ldma_req,
    input  wire logic [`MBX_CHANS-1:0]     ldma_ack,
    input  wire logic [`MBX_CHANS-1:0]     ldma_wr,
    input  wire logic [`MBX_CHANS-1:0]     ldma_tc,
    input  wire mailbox_pkg::byte_t        ldma_wdata,
    output logic [`MBX_CHANS*`MBX_DW-1:0]  ldma_rdata,
    // isa host pins
    input  wire logic                      chan0_host_ack_n,
    input  wire logic                      chan1_host_ack_n,
    input  wire logic                      isa_read_strobe_n,
    input  wire logic                      isa_write_strobe_n,
    output logic                           chan0_request_line,
    output logic                           chan0_request_line_oe,
    output logic                           chan1_request_line,
    output logic                           chan1_request_line_oe,
    output logic                           host_bus_drive_enable_n,
    // card host pins
    input  wire logic                      card_register_select,
    input  wire logic                      card_read_strobe_n,
    input  wire logic                      card_write_strobe_n,
    output logic                           card_request_out_n,
    // shared host data bus
    input  wire mailbox_pkg::byte_t        host_data_bus_in,
    output mailbox_pkg::byte_t             host_data_bus_out,
    output logic                           host_data_bus_oe
);
    import mailbox_pkg::*;

    mbx_state_t st_q, st_d;
    logic [6:0]            pins_s;
    byte_t                 hdata_s;
    logic [`MBX_CHANS-1:0] host_ack, rcyc_now, wcyc_now, rd_trail, wr_trail;
    logic [`MBX_CHANS-1:0] host_req, buf_in_valid, buf_in_ready, buf_out_valid;
    logic [`MBX_CHANS-1:0] buf_out_ready, refill, fetch;
    logic                  rd_s, wr_s;

    //--------------------------------------------------------------
    // pin synchronisers and host cycle decode
    //--------------------------------------------------------------
    pin_sync #(.WIDTH(7), .IDLE(`MBX_PIN_IDLE)) u_pin_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .raw     ({card_register_select, card_write_strobe_n, card_read_strobe_n,
                   isa_write_strobe_n, isa_read_strobe_n, chan1_host_ack_n,
                   chan0_host_ack_n}),
        .clean   (pins_s)
    );

    pin_sync #(.WIDTH(`MBX_DW), .IDLE('0)) u_data_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .raw     (host_data_bus_in),
        .clean   (hdata_s)
    );

    // card mode has one acknowledge, so channel 1 never sees a cycle there
    assign host_ack[0] = isa_mode ? ~pins_s[0] : pins_s[6];
    assign host_ack[1] = isa_mode & ~pins_s[1];
    assign rd_s        = isa_mode ? ~pins_s[2] : ~pins_s[4];
    assign wr_s        = isa_mode ? ~pins_s[3] : ~pins_s[5];
    assign rcyc_now    = host_ack & {`MBX_CHANS{rd_s}};
    assign wcyc_now    = host_ack & {`MBX_CHANS{wr_s}};
    assign rd_trail    = st_q.rcyc & ~rcyc_now;
    assign wr_trail    = st_q.wcyc & ~wcyc_now;

    //--------------------------------------------------------------
    // per-channel request terms and drain buffers
    //--------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < `MBX_CHANS; c++)
        begin : g_chan
            // trail terms cover the cycle before the flag clears
            assign host_req[c] = st_q.flag[c] & ~rcyc_now[c] & ~wcyc_now[c]
                               & ~rd_trail[c] & ~wr_trail[c]
                               & ((st_q.mode[c] != MODE_HOST_WRITE) | buf_in_ready[c]);
            assign buf_in_valid[c]  = wr_trail[c] & (st_q.mode[c] == MODE_HOST_WRITE);
            assign buf_out_ready[c] = ldma_ack[c] & (st_q.mode[c] == MODE_HOST_WRITE);
            assign refill[c]        = buf_out_valid[c] & buf_out_ready[c];
            // fed reads ask for a byte while the flag is clear and ldma_tc is low
            assign fetch[c] = (st_q.mode[c] == MODE_HOST_READ) & ~st_q.flag[c]
                            & ~ldma_tc[c];
            assign ldma_req[c] = (st_q.mode[c] == MODE_HOST_WRITE) ? buf_out_valid[c]
                                                                   : fetch[c];

            byte_buffer #(.WIDTH(`MBX_DW), .DEPTH(`MBX_BUF_DEPTH)) u_buf (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .in_valid  (buf_in_valid[c]),
                .in_ready  (buf_in_ready[c]),
                .in_data   (st_q.capture[c]),
                .out_valid (buf_out_valid[c]),
                .out_ready (buf_out_ready[c]),
                .out_data  (ldma_rdata[c*`MBX_DW +: `MBX_DW])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // host pin drive
    //--------------------------------------------------------------
    assign chan0_request_line      = host_req[0];
    assign chan1_request_line      = host_req[1];
    assign chan0_request_line_oe   = isa_mode & chan_enable[0];
    assign chan1_request_line_oe   = isa_mode & chan_enable[1];
    assign card_request_out_n      = ~(~isa_mode & chan_enable[0] & host_req[0]);
    assign host_data_bus_oe        = |rcyc_now;
    assign host_bus_drive_enable_n = ~(isa_mode & (|rcyc_now));
    assign host_data_bus_out       = st_q.hdata;
    assign loc_rdata               = st_q.rdata;

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb
    begin
        logic old_en;
        logic new_en;
        old_en     = 1'b0;
        new_en     = 1'b0;
        st_d       = st_q;
        st_d.rcyc  = rcyc_now;
        st_d.wcyc  = wcyc_now;
        // data for the bus follows whichever acknowledge is active
        st_d.hdata = st_q.to_host[host_ack[1]];
        for (int i = 0; i < `MBX_CHANS; i++)
        begin
            old_en = st_q.assign_reg[`MBX_EN_BIT + i*`MBX_EN_STRIDE];
            new_en = loc_wdata[`MBX_EN_BIT + i*`MBX_EN_STRIDE];
            if (wcyc_now[i])
            begin
                st_d.capture[i] = hdata_s;
            end
            if (wr_trail[i])
            begin
                st_d.from_host[i] = st_q.capture[i];
            end
            if (loc_wr && loc_addr == `MBX_ADDR_DATA0 + `MBX_AW'(i))
            begin
                st_d.to_host[i] = loc_wdata;
            end
            if (ldma_wr[i])
            begin
                st_d.to_host[i] = ldma_wdata;
            end
            if (loc_rd && loc_addr == `MBX_ADDR_DATA0 + `MBX_AW'(i))
            begin
                st_d.valid[i] = 1'b0;
            end
            // mode is chosen when enable rises: flag already set means drained write
            if (loc_wr && loc_addr == `MBX_ADDR_ASSIGN)
            begin
                if (!new_en)
                begin
                    st_d.mode[i] = MODE_POLL;
                end
                else if (!old_en)
                begin
                    st_d.mode[i] = st_q.flag[i] ? MODE_HOST_WRITE : MODE_HOST_READ;
                end
            end
            // software write, then hardware clear, then hardware set: set wins
            if (loc_wr && loc_addr == `MBX_ADDR_CTRL && loc_wdata[`MBX_WE_BIT + i])
            begin
                st_d.flag[i] = loc_wdata[`MBX_REQ_BIT + i];
            end
            if (rd_trail[i] || wr_trail[i])
            begin
                st_d.flag[i] = 1'b0;
            end
            if ((ldma_wr[i] && st_q.mode[i] != MODE_HOST_WRITE) || refill[i])
            begin
                st_d.flag[i] = 1'b1;
            end
        end
        if (loc_wr && loc_addr == `MBX_ADDR_ASSIGN)
        begin
            st_d.assign_reg = loc_wdata;
        end
        // read data is registered; unmapped addresses answer zero
        if (loc_rd)
        begin
            unique case (loc_addr)
                `MBX_ADDR_DATA0:  st_d.rdata = st_q.from_host[0];
                `MBX_ADDR_DATA1:  st_d.rdata = st_q.from_host[1];
                `MBX_ADDR_CTRL:   st_d.rdata = byte_t'({st_q.valid, st_q.flag}) << `MBX_REQ_BIT;
                `MBX_ADDR_ASSIGN: st_d.rdata = st_q.assign_reg;
                default:          st_d.rdata = '0;
            endcase
        end
        if (reset)
        begin
            st_d           = '0;
            st_d.valid     = '1;
            st_d.from_host = {ID_CODE1, ID_CODE0};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_rd_active;
        rcyc_now[0] ##1 !rcyc_now[0];
    endsequence

    property p_rd_drive;
        rcyc_now[0] |-> host_data_bus_oe && !host_req[0]
            && (host_bus_drive_enable_n == !isa_mode);
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read cycle not driving");

    property p_rd_release;
        s_rd_active ##0 !ldma_wr[0] |=> !st_q.flag[0];
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("read end kept flag");

    property p_wr_negate;
        wcyc_now[0] && st_q.flag[0] |-> !chan0_request_line ##1 st_q.flag[0] || !wcyc_now[0];
    endproperty
    a_wr_negate: assert property (p_wr_negate) else $error("write request not dropped");

    property p_wr_latch;
        wr_trail[0] |=> st_q.from_host[0] == $past(st_q.capture[0]);
    endproperty
    a_wr_latch: assert property (p_wr_latch) else $error("host byte not latched");

    property p_ldma_raise;
        buf_in_valid[0] && buf_in_ready[0] |=> ##[0:1] ldma_req[0];
    endproperty
    a_ldma_raise: assert property (p_ldma_raise) else $error("no local request");

    property p_refill;
        refill[0] && !rd_trail[0] && !wr_trail[0] |=> st_q.flag[0] && !ldma_req[0];
    endproperty
    a_refill: assert property (p_refill) else $error("flag not re-armed");

    property p_deposit;
        ldma_wr[0] && st_q.mode[0] == MODE_HOST_READ
            |=> st_q.flag[0] && st_q.to_host[0] == $past(ldma_wdata);
    endproperty
    a_deposit: assert property (p_deposit) else $error("deposit lost");

    property p_fetch;
        st_q.mode[0] == MODE_HOST_READ && !st_q.flag[0] && !ldma_tc[0] |-> ldma_req[0];
    endproperty
    a_fetch: assert property (p_fetch) else $error("no fetch request");

    property p_valid_clr;
        loc_rd && loc_addr == `MBX_ADDR_DATA0 |=> !st_q.valid[0] [*2];
    endproperty
    a_valid_clr: assert property (p_valid_clr) else $error("valid not cleared");

    property p_we_guard;
        loc_wr && loc_addr == `MBX_ADDR_CTRL && !loc_wdata[`MBX_WE_BIT]
            && !rd_trail[0] && !wr_trail[0] && !ldma_wr[0] && !refill[0]
            |=> st_q.flag[0] == $past(st_q.flag[0]);
    endproperty
    a_we_guard: assert property (p_we_guard) else $error("flag written without enable");

    //--------------------------------------------------------------
    // assertions: bus data, registers and pin modes
    //--------------------------------------------------------------
    // the bus byte lags the acknowledge by one flop, so the first cycle is skipped
    property p_rd_data;
        rcyc_now[0] && $past(rcyc_now[0]) && !$past(host_ack[1])
            |-> host_data_bus_out == $past(st_q.to_host[0]);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte wrong");

    property p_rd_free;
        s_rd_active ##0 !rcyc_now[1] |-> !host_data_bus_oe && host_bus_drive_enable_n;
    endproperty
    a_rd_free: assert property (p_rd_free) else $error("bus held after read");

    sequence s_wr_active;
        wcyc_now[0] ##1 !wcyc_now[0];
    endsequence

    property p_wr_clear;
        s_wr_active ##0 !ldma_wr[0] && !refill[0] |=> !st_q.flag[0];
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write end kept flag");

    property p_ldma_data;
        ldma_req[0] && st_q.mode[0] == MODE_HOST_WRITE
            |-> ldma_rdata[`MBX_DW-1:0] == st_q.from_host[0];
    endproperty
    a_ldma_data: assert property (p_ldma_data) else $error("local byte wrong");

    property p_data_write;
        loc_wr && loc_addr == `MBX_ADDR_DATA0 && !ldma_wr[0]
            |=> st_q.to_host[0] == $past(loc_wdata);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_assign_write;
        loc_wr && loc_addr == `MBX_ADDR_ASSIGN |=> st_q.assign_reg == $past(loc_wdata);
    endproperty
    a_assign_write: assert property (p_assign_write) else $error("assign lost");

    property p_pin_float;
        !isa_mode || !chan_enable[1] |-> !chan1_request_line_oe;
    endproperty
    a_pin_float: assert property (p_pin_float) else $error("request pin driven");

    property p_card_only0;
        !isa_mode |-> !host_ack[1] && !rcyc_now[1] && !wcyc_now[1];
    endproperty
    a_card_only0: assert property (p_card_only0) else $error("card ch1 busy");

    property p_card_idle;
        isa_mode || !chan_enable[0] || rcyc_now[0] || wcyc_now[0] |-> card_request_out_n;
    endproperty
    a_card_idle: assert property (p_card_idle) else $error("card request wrong");
endmodule

// [verification/host_dma_model.sv]
// Purpose: behavioural host dma controller on the isa pins
// Assumes: one transfer per raised request while armed
// Notes:   strobe held 6 cycles, 12 when slow; 8-cycle gap after each
`timescale 1ns/1ps
module host_dma_model (
    // clock
    input  wire logic       sys_clk,
    // bench control
    input  wire logic       armed,
    input  wire logic       dir_write,
    input  wire logic       slow,
    input  wire logic [7:0] wdata,
    // device side
    input  wire logic [1:0] req,
    input  wire logic [7:0] bus,
    output logic      [1:0] ack_n,
    output logic            isa_read_strobe_n,
    output logic            isa_write_strobe_n,
    output logic            drive,
    output logic      [7:0] hdata,
    output logic      [7:0] got
);
    int ch;
    // auto-initialised controller: ready whenever armed and a request shows
    initial
    begin
        ack_n = 2'b11;
        isa_read_strobe_n = 1'b1;
        isa_write_strobe_n = 1'b1;
        drive = 1'b0;
        hdata = 8'h00;
        got = 8'h00;
        forever
        begin
            @(negedge sys_clk);
            if (armed && req != 2'b00)
            begin
                ch = req[0] ? 0 : 1;
                hdata = wdata;
                drive = dir_write; // data valid from the start of the strobe and during it
                ack_n[ch] = 1'b0;
                isa_write_strobe_n = !dir_write;
                isa_read_strobe_n = dir_write;
                repeat (slow ? 12 : 6) @(negedge sys_clk);
                got = bus;
                ack_n = 2'b11;
                isa_read_strobe_n = 1'b1;
                isa_write_strobe_n = 1'b1;
                // hold data past the strobe since the device samples it late
                repeat (2) @(negedge sys_clk);
                drive = 1'b0;
                repeat (6) @(negedge sys_clk);
            end
        end
    end
endmodule

// [verification/tb_host_dma_mailbox.sv]
// Purpose: self-checking bench of the host dma mailbox
// Assumes: isa pins driven by the model; card pins by one scenario
// Notes:   register reads go through the local port, not peeks
`timescale 1ns/1ps
module tb_host_dma_mailbox;
    import mailbox_pkg::*;
    logic sys_clk = 0, reset = 1, isa_mode = 1, loc_wr = 0, loc_rd = 0;
    logic armed = 0, dir_write = 0, slow = 0, drive, hdm_oe;
    logic [1:0] chan_enable = 2'b11, ldma_req, ldma_ack = 0, ldma_wr = 0, ldma_tc = 0, ack_n;
    logic [15:0] loc_addr = 0, ldma_rdata;
    byte_t loc_wdata = 0, loc_rdata, ldma_wdata = 0, host_data_bus_out, hdata, got, wdata = 0;
    logic chan0_request_line, chan0_request_line_oe, chan1_request_line, chan1_request_line_oe;
    logic host_bus_drive_enable_n, card_request_out_n, host_data_bus_oe, isa_read_strobe_n;
    logic isa_write_strobe_n;
    logic card_sel = 0, card_rd_n = 1;
    wire [7:0] bus = host_data_bus_oe ? host_data_bus_out : (drive ? hdata : ~hdata);
    int err_total = 0, num_checks = 0, cycles = 0, bad_req = 0;
    byte_t d;
    always #20 sys_clk = ~sys_clk;
    host_dma_mailbox #(.ID_CODE0(8'h5A), .ID_CODE1(8'hC3)) i_host_dma_mailbox (
        .sys_clk, .reset, .isa_mode, .chan_enable, .loc_addr, .loc_wr, .loc_rd, .loc_wdata,
        .loc_rdata, .ldma_req, .ldma_ack, .ldma_wr, .ldma_tc, .ldma_wdata, .ldma_rdata,
        .chan0_host_ack_n(ack_n[0]), .chan1_host_ack_n(ack_n[1]), .isa_read_strobe_n,
        .isa_write_strobe_n, .chan0_request_line, .chan0_request_line_oe, .chan1_request_line,
        .chan1_request_line_oe, .host_bus_drive_enable_n, .card_register_select(card_sel),
        .card_read_strobe_n(card_rd_n), .card_write_strobe_n(1'b1), .card_request_out_n,
        .host_data_bus_in(bus), .host_data_bus_out, .host_data_bus_oe);
    host_dma_model i_host_dma_model (.sys_clk, .armed, .dir_write, .slow, .wdata,
        .req({chan1_request_line, chan0_request_line}), .bus, .ack_n, .isa_read_strobe_n,
        .isa_write_strobe_n, .drive, .hdata, .got);
    // the request must be down whenever the device drives the host bus
    always @(negedge sys_clk)
        if (host_data_bus_oe === 1'b1 && ({chan1_request_line, chan0_request_line} !== 2'b00
                || host_bus_drive_enable_n !== !isa_mode)) bad_req++;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin err_total++; $display("[ERR] %s exp %h seen %h", what, exp, seen); end
    endtask
    task automatic lw(input logic [15:0] a, input byte_t v);
        @(negedge sys_clk); loc_addr = a; loc_wdata = v; loc_wr = 1;
        @(negedge sys_clk); loc_wr = 0;
    endtask
    task automatic lr(input logic [15:0] a, output byte_t v);
        @(negedge sys_clk); loc_addr = a; loc_rd = 1;
        @(negedge sys_clk); loc_rd = 0; v = loc_rdata;
    endtask
    // software polls the flag with a bounded count
    task automatic wait_flag(input byte_t m);
        byte_t v = m;
        int n = 0;
        while ((v & m) !== 8'h00 && n < 80) begin lr(16'h00D2, v); n++; end
        chk("flag clear", v & m, 8'h00);
    endtask
    task automatic wait_ldreq(input int c);
        int n = 0;
        while (ldma_req[c] !== 1'b1 && n < 60) begin @(negedge sys_clk); n++; end
        chk("ldma_req up", ldma_req[c], 1'b1);
    endtask
    task automatic t_reset;
        lr(16'h00D2, d); chk("ctrl reset", d, 8'hC0);
        lr(16'h00D0, d); chk("id0", d, 8'h5A);
        lr(16'h00D2, d); chk("valid0 clr", d, 8'h80);
        lr(16'h00D1, d); chk("id1", d, 8'hC3);
        lr(16'h00D2, d); chk("valid1 clr", d, 8'h00);
        lr(16'h00E6, d); chk("assign reset", d, 8'h00);
        lr(16'h00D3, d); chk("unmapped", d, 8'h00);
        chk("oe pins", {chan1_request_line_oe, chan0_request_line_oe}, 2'b11);
        $display("test reset done");
    endtask
    task automatic t_we;
        lw(16'h00D2, 8'h30); lr(16'h00D2, d); chk("no we", d, 8'h00);
        $display("test write_enable done");
    endtask
    task automatic t_poll_read;
        lw(16'h00D2, 8'h40); // clear first
        lw(16'h00D0, 8'h55); lw(16'h00D2, 8'h50); // byte then flag
        @(negedge sys_clk); chk("req0 up", chan0_request_line, 1'b1);
        dir_write = 0; armed = 1;
        wait_flag(8'h10); armed = 0;
        chk("host got", got, 8'h55);
        chk("drv en idle", {host_bus_drive_enable_n, host_data_bus_oe}, 2'b10);
        chk("req in read", bad_req, 0);
        $display("test polled_read done");
    endtask
    task automatic t_poll_write;
        lw(16'h00D2, 8'hA0); slow = 1; wdata = 8'h9A; dir_write = 1; armed = 1;
        wait_flag(8'h20); armed = 0; slow = 0;
        lr(16'h00D1, d); chk("from host1", d, 8'h9A);
        $display("test polled_write done");
    endtask
    task automatic t_drain_write;
        lw(16'h00D2, 8'h50); lw(16'h00E6, 8'h08); // flag then enable
        wdata = 8'h3C; dir_write = 1; armed = 1;
        wait_ldreq(0); armed = 0;
        chk("req0 low", chan0_request_line, 1'b0);
        chk("ldma byte", ldma_rdata[7:0], 8'h3C);
        ldma_ack[0] = 1; @(negedge sys_clk); ldma_ack[0] = 0;
        repeat (2) @(negedge sys_clk);
        chk("ldma drop", ldma_req[0], 1'b0);
        chk("req0 again", chan0_request_line, 1'b1);
        lw(16'h00E6, 8'h00); lw(16'h00D2, 8'h40); // cancel
        $display("test drained_write done");
    endtask
    task automatic t_fed_read;
        lw(16'h00E6, 8'h80); wait_ldreq(1); // enable, no flag
        ldma_wdata = 8'h77; ldma_wr[1] = 1; @(negedge sys_clk); ldma_wr[1] = 0;
        @(negedge sys_clk); chk("req1 up", chan1_request_line, 1'b1);
        dir_write = 0; armed = 1;
        wait_flag(8'h20); armed = 0;
        chk("host got", got, 8'h77);
        wait_ldreq(1);
        ldma_tc[1] = 1; repeat (2) @(negedge sys_clk);
        chk("tc stops", ldma_req[1], 1'b0);
        $display("test fed_read done");
    endtask
    task automatic t_card;
        isa_mode = 0; lw(16'h00D2, 8'h50);
        @(negedge sys_clk);
        chk("card req", {card_request_out_n, chan0_request_line_oe}, 2'b00);
        card_sel = 1; card_rd_n = 0; repeat (6) @(negedge sys_clk);
        chk("card bus", {host_data_bus_oe, host_bus_drive_enable_n, host_data_bus_out},
            10'h355);
        card_sel = 0; card_rd_n = 1; wait_flag(8'h10);
        chk("card idle", card_request_out_n, 1'b1);
        chk("req in read", bad_req, 0);
        isa_mode = 1;
        $display("test card_read done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000) begin err_total++; conclude(); end
    end
    initial
    begin
        repeat (8) @(negedge sys_clk);
        reset = 0;
        repeat (4) @(negedge sys_clk);
        t_reset(); t_we(); t_poll_read(); t_poll_write(); t_drain_write(); t_fed_read();
        t_card();
        conclude();
    end
endmodule
